// File: verilog/accel_offset_fifo_defines.svh
// register indices, field positions, reset values and sizes for the
// accelerometer offset and queue register group; byte address = 4 * index
`ifndef ACCEL_OFFSET_FIFO_DEFINES_SVH
`define ACCEL_OFFSET_FIFO_DEFINES_SVH

// register indices
`define IDX_QUEUE_STATUS   6'h0e
`define IDX_SOFT_RESET     6'h14
`define IDX_NV_CONTROL     6'h33
`define IDX_COMP_CONTROL   6'h36
`define IDX_OFFSET_X       6'h38
`define IDX_OFFSET_Y       6'h39
`define IDX_OFFSET_Z       6'h3a
`define IDX_NV_IMAGE_A     6'h3b
`define IDX_NV_IMAGE_B     6'h3c
`define IDX_QUEUE_CONFIG   6'h3e
`define IDX_QUEUE_READOUT  6'h3f

// soft reset command byte
`define SOFT_RESET_CODE    8'hb6

// nv control fields
`define NV_LOAD_BIT        3
`define NV_READY_BIT       2
`define NV_PROG_TRIG_BIT   1
`define NV_PROG_MODE_BIT   0

// compensation control fields
`define COMP_RESET_BIT     7
`define COMP_TRIG_HI       6
`define COMP_TRIG_LO       5
`define COMP_READY_BIT     4

// queue configuration fields
`define CFG_MODE_HI        7
`define CFG_MODE_LO        6
`define CFG_SEL_HI         1
`define CFG_SEL_LO         0

// reset values
`define OFFSET_RESET       8'h00
`define NV_IMAGE_RESET     8'h00
`define CONFIG_RESET       8'h00

// queue geometry
`define QUEUE_DEPTH        6'd32
`define LAST_BYTE_ALL      3'd5
`define LAST_BYTE_ONE      3'd1

// byte lanes of the non-volatile image bus
`define NV_X_LSB           0
`define NV_Y_LSB           8
`define NV_Z_LSB           16
`define NV_A_LSB           24
`define NV_B_LSB           32

`endif

// File: verilog/accel_offset_fifo_pkg.sv
// types shared by the accelerometer offset and queue register group
package accel_offset_fifo_pkg;

  typedef enum logic [1:0] {
    MODE_BYPASS = 2'b00,
    MODE_FIFO   = 2'b01,
    MODE_STREAM = 2'b10,
    MODE_RSVD   = 2'b11
  } queue_mode_e;

  typedef enum logic [1:0] {
    SEL_XYZ = 2'b00,
    SEL_X   = 2'b01,
    SEL_Y   = 2'b10,
    SEL_Z   = 2'b11
  } axis_sel_e;

  // data scale: 2 g, 4 g, 8 g, 16 g full range of 12-bit samples
  typedef enum logic [1:0] {
    RANGE_2G  = 2'b00,
    RANGE_4G  = 2'b01,
    RANGE_8G  = 2'b10,
    RANGE_16G = 2'b11
  } g_range_e;

  typedef logic [11:0] sample_t;

endpackage

// File: verilog/accel_offset_fifo_regs.sv
// offset, spare image and queue registers of the accelerometer
// assumes an avalon-mm master, a sampler giving one-cycle sample strobes,
// an external compensation engine and an external non-volatile store
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "accel_offset_fifo_defines.svh"

module accel_offset_fifo_regs (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // avalon-mm slave
  input  wire logic [7:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // serial front end
  input  wire logic        HOST_BURST_END,
  output logic      [5:0]  NEXT_BURST_INDEX,
  // acceleration samples
  input  wire logic        SAMPLE_VALID,
  input  wire logic [1:0]  G_RANGE,
  input  wire logic [11:0] DATA_FILT_X,
  input  wire logic [11:0] DATA_FILT_Y,
  input  wire logic [11:0] DATA_FILT_Z,
  input  wire logic [11:0] DATA_RAW_X,
  input  wire logic [11:0] DATA_RAW_Y,
  input  wire logic [11:0] DATA_RAW_Z,
  // compensated data and queue full flag
  output logic      [11:0] COMP_FILT_X,
  output logic      [11:0] COMP_FILT_Y,
  output logic      [11:0] COMP_FILT_Z,
  output logic      [11:0] COMP_RAW_X,
  output logic      [11:0] COMP_RAW_Y,
  output logic      [11:0] COMP_RAW_Z,
  output logic             FIFO_FULL,
  // fast compensation engine
  output logic             CAL_START,
  output logic      [1:0]  CAL_AXIS,
  input  wire logic        CAL_DONE,
  input  wire logic [7:0]  CAL_RESULT,
  // non-volatile store
  input  wire logic        NVM_BUSY,
  input  wire logic [3:0]  NVM_REMAIN,
  input  wire logic [39:0] NVM_IMAGE,
  output logic             NVM_PROG,
  output logic      [39:0] NVM_PROG_DATA
);

  // offset scaled to the sample lsb, then clipped to 12 bits
  function automatic logic [11:0] sat_add(input logic [11:0] d,
                                          input logic [7:0]  o,
                                          input logic [1:0]  rng);
    logic [13:0] so;
    logic [13:0] sum;
    so = {{6{o[7]}}, o};
    case (rng)
      accel_offset_fifo_pkg::RANGE_2G: so = so <<< 3;
      accel_offset_fifo_pkg::RANGE_4G: so = so <<< 2;
      accel_offset_fifo_pkg::RANGE_8G: so = so <<< 1;
      default:                         so = so;
    endcase
    sum = {{2{d[11]}}, d} + so;
    if (!sum[13] && sum[12:11] != 2'b00)
      sat_add = 12'h7ff;
    else if (sum[13] && sum[12:11] != 2'b11)
      sat_add = 12'h800;
    else
      sat_add = sum[11:0];
  endfunction

  // register index match
  function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
    hit = (a == r);
  endfunction

  // burst address step, parked at the readout index
  function automatic logic [5:0] burst_next(input logic [5:0] a);
    if (a == `IDX_QUEUE_READOUT)
      burst_next = a;
    else
      burst_next = a + 6'h01;
  endfunction

  logic        rst_meta;
  logic        rst_n;
  logic        init;
  logic [5:0]  idx;
  logic        access;
  logic        wr_acc;
  logic        rd_acc;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [7:0]  off_x;
  logic [7:0]  off_y;
  logic [7:0]  off_z;
  logic [7:0]  spare_byte_a;
  logic [7:0]  spare_byte_b;
  logic        cal_rdy;
  logic        prog_mode;
  logic        cal_trig;
  logic        nv_reload;
  logic        nv_prog_ok;
  logic [1:0]  q_mode;
  logic [1:0]  q_sel;
  logic [35:0] mem [0:31];
  logic [4:0]  wr_ptr;
  logic [4:0]  rd_ptr;
  logic [5:0]  count;
  logic [2:0]  byte_idx;
  logic        overrun;
  logic        cfg_write;
  logic        q_full;
  logic        pop_byte;
  logic        last_byte;
  logic        discard;
  logic        pop_frame;
  logic        push_ok;
  logic        drop;
  logic        do_pop;
  logic [35:0] push_frame;
  logic [35:0] head;
  logic [1:0]  axis;
  logic [11:0] head_word;
  logic [7:0]  queue_byte;

  // reset release through two flops
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // bus decode; one wait state, request taken on the first edge
  assign idx    = AVS_ADDRESS[7:2];
  assign access = (AVS_READ | AVS_WRITE) & AVS_WAITREQUEST;
  assign wr_acc = access & AVS_WRITE & AVS_BYTEENABLE[0];
  assign rd_acc = access & AVS_READ;
  assign wbyte  = AVS_WRITEDATA[7:0];

  // wait state generator
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= ~access;
  end

  // init pulse after reset release and after a soft reset command
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n)
      init <= 1'b1;
    else
      init <= wr_acc && hit(idx, `IDX_SOFT_RESET) &&
              wbyte == `SOFT_RESET_CODE;
  end

  // store requests; lock state sampled before this write takes hold
  assign nv_reload  = wr_acc && hit(idx, `IDX_NV_CONTROL) &&
                      wbyte[`NV_LOAD_BIT] && !NVM_BUSY;
  assign nv_prog_ok = wr_acc && hit(idx, `IDX_NV_CONTROL) &&
                      wbyte[`NV_PROG_TRIG_BIT] && prog_mode &&
                      NVM_REMAIN != 4'h0 && !NVM_BUSY;

  // axis offsets; compensation result is applied after bus writes so it wins over them, but init and store reload win over it
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      off_x <= `OFFSET_RESET;
      off_y <= `OFFSET_RESET;
      off_z <= `OFFSET_RESET;
    end else if (init || nv_reload) begin
      off_x <= NVM_IMAGE[`NV_X_LSB +: 8];
      off_y <= NVM_IMAGE[`NV_Y_LSB +: 8];
      off_z <= NVM_IMAGE[`NV_Z_LSB +: 8];
    end else begin
      if (wr_acc && hit(idx, `IDX_COMP_CONTROL) &&
          wbyte[`COMP_RESET_BIT]) begin
        off_x <= `OFFSET_RESET;
        off_y <= `OFFSET_RESET;
        off_z <= `OFFSET_RESET;
      end else if (wr_acc && hit(idx, `IDX_OFFSET_X)) begin
        off_x <= wbyte;
      end else if (wr_acc && hit(idx, `IDX_OFFSET_Y)) begin
        off_y <= wbyte;
      end else if (wr_acc && hit(idx, `IDX_OFFSET_Z)) begin
        off_z <= wbyte;
      end
      if (CAL_DONE) begin
        case (CAL_AXIS)
          2'b01:   off_x <= CAL_RESULT;
          2'b10:   off_y <= CAL_RESULT;
          2'b11:   off_z <= CAL_RESULT;
          default: ;
        endcase
      end
    end
  end

  // spare bytes with store backing
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      spare_byte_a <= `NV_IMAGE_RESET;
      spare_byte_b <= `NV_IMAGE_RESET;
    end else if (init || nv_reload) begin
      spare_byte_a <= NVM_IMAGE[`NV_A_LSB +: 8];
      spare_byte_b <= NVM_IMAGE[`NV_B_LSB +: 8];
    end else if (wr_acc && hit(idx, `IDX_NV_IMAGE_A)) begin
      spare_byte_a <= wbyte;
    end else if (wr_acc && hit(idx, `IDX_NV_IMAGE_B)) begin
      spare_byte_b <= wbyte;
    end
  end

  // store programming request and image snapshot
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      prog_mode     <= 1'b0;
      NVM_PROG      <= 1'b0;
      NVM_PROG_DATA <= 40'h0;
    end else begin
      NVM_PROG <= nv_prog_ok;
      if (nv_prog_ok)
        NVM_PROG_DATA <= {spare_byte_b, spare_byte_a, off_z, off_y, off_x};
      if (init)
        prog_mode <= 1'b0;
      else if (wr_acc && hit(idx, `IDX_NV_CONTROL))
        prog_mode <= wbyte[`NV_PROG_MODE_BIT];
    end
  end

  // trigger ignored while a compensation is still running
  assign cal_trig = wr_acc && hit(idx, `IDX_COMP_CONTROL) &&
                    wbyte[`COMP_TRIG_HI:`COMP_TRIG_LO] != 2'b00 &&
                    cal_rdy;

  // fast compensation handshake
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cal_rdy   <= 1'b1;
      CAL_START <= 1'b0;
      CAL_AXIS  <= 2'b00;
    end else begin
      CAL_START <= cal_trig;
      if (cal_trig) begin
        CAL_AXIS <= wbyte[`COMP_TRIG_HI:`COMP_TRIG_LO];
        cal_rdy  <= 1'b0;
      end else if (CAL_DONE || init) begin
        cal_rdy <= 1'b1;
      end
    end
  end

  // queue configuration
  assign cfg_write = wr_acc && hit(idx, `IDX_QUEUE_CONFIG);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q_mode <= 2'(`CONFIG_RESET >> `CFG_MODE_LO);
      q_sel  <= 2'b00;
    end else if (init) begin
      q_mode <= 2'b00;
      q_sel  <= 2'b00;
    end else if (cfg_write) begin
      q_mode <= wbyte[`CFG_MODE_HI:`CFG_MODE_LO];
      q_sel  <= wbyte[`CFG_SEL_HI:`CFG_SEL_LO];
    end
  end

  // compensated data, filtered and raw
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      COMP_FILT_X <= 12'h000;
      COMP_FILT_Y <= 12'h000;
      COMP_FILT_Z <= 12'h000;
      COMP_RAW_X  <= 12'h000;
      COMP_RAW_Y  <= 12'h000;
      COMP_RAW_Z  <= 12'h000;
    end else begin
      COMP_FILT_X <= sat_add(DATA_FILT_X, off_x, G_RANGE);
      COMP_FILT_Y <= sat_add(DATA_FILT_Y, off_y, G_RANGE);
      COMP_FILT_Z <= sat_add(DATA_FILT_Z, off_z, G_RANGE);
      COMP_RAW_X  <= sat_add(DATA_RAW_X, off_x, G_RANGE);
      COMP_RAW_Y  <= sat_add(DATA_RAW_Y, off_y, G_RANGE);
      COMP_RAW_Z  <= sat_add(DATA_RAW_Z, off_z, G_RANGE);
    end
  end

  // queue control terms
  assign push_frame = {sat_add(DATA_FILT_Z, off_z, G_RANGE),
                       sat_add(DATA_FILT_Y, off_y, G_RANGE),
                       sat_add(DATA_FILT_X, off_x, G_RANGE)};
  assign q_full    = (count == `QUEUE_DEPTH);
  assign last_byte = (q_sel == accel_offset_fifo_pkg::SEL_XYZ) ?
                     (byte_idx == `LAST_BYTE_ALL) :
                     (byte_idx == `LAST_BYTE_ONE);
  assign pop_byte  = rd_acc && hit(idx, `IDX_QUEUE_READOUT) &&
                     count != 6'd0;
  // leaving mid-frame, by another access or end of burst, drops it
  assign discard   = (HOST_BURST_END ||
                      (access && !hit(idx, `IDX_QUEUE_READOUT))) &&
                     byte_idx != 3'd0 && count != 6'd0;
  assign pop_frame = (pop_byte && last_byte) || (discard && !pop_byte);
  assign push_ok   = SAMPLE_VALID &&
                     ((q_mode == accel_offset_fifo_pkg::MODE_STREAM) ||
                      (q_mode == accel_offset_fifo_pkg::MODE_FIFO &&
                       (!q_full || pop_frame)));
  assign drop      = SAMPLE_VALID && q_full && !pop_frame &&
                     q_mode == accel_offset_fifo_pkg::MODE_STREAM;
  assign do_pop    = pop_frame || drop;

  // frame storage; a single write port, no reset needed
  always_ff @(posedge CLK) begin
    if (SAMPLE_VALID && q_mode != accel_offset_fifo_pkg::MODE_RSVD &&
        (push_ok || q_mode == accel_offset_fifo_pkg::MODE_BYPASS))
      mem[wr_ptr] <= push_frame;
  end

  // pointers, fill count, byte position and overrun
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr   <= 5'h00;
      rd_ptr   <= 5'h00;
      count    <= 6'd0;
      byte_idx <= 3'd0;
      overrun  <= 1'b0;
    end else if (init || cfg_write) begin
      wr_ptr   <= 5'h00;
      rd_ptr   <= 5'h00;
      count    <= 6'd0;
      byte_idx <= 3'd0;
      overrun  <= 1'b0;
    end else if (q_mode == accel_offset_fifo_pkg::MODE_BYPASS &&
                 SAMPLE_VALID) begin
      rd_ptr   <= wr_ptr;
      wr_ptr   <= wr_ptr + 5'h01;
      count    <= 6'd1;
      byte_idx <= 3'd0;
    end else begin
      if (do_pop)
        rd_ptr <= rd_ptr + 5'h01;
      if (push_ok)
        wr_ptr <= wr_ptr + 5'h01;
      case ({push_ok, do_pop})
        2'b10:   count <= count + 6'd1;
        2'b01:   count <= count - 6'd1;
        default: count <= count;
      endcase
      if (do_pop)
        byte_idx <= 3'd0;
      else if (pop_byte)
        byte_idx <= byte_idx + 3'd1;
      if (drop || (SAMPLE_VALID && !push_ok &&
                   q_mode == accel_offset_fifo_pkg::MODE_FIFO))
        overrun <= 1'b1;
    end
  end

  // byte picked from the oldest frame
  assign head = mem[rd_ptr];
  assign axis = (q_sel == accel_offset_fifo_pkg::SEL_XYZ) ?
                byte_idx[2:1] : q_sel - 2'b01;
  always_comb begin
    case (axis)
      2'b00:   head_word = head[11:0];
      2'b01:   head_word = head[23:12];
      default: head_word = head[35:24];
    endcase
    if (count == 6'd0)
      queue_byte = 8'h00;
    else if (byte_idx[0])
      queue_byte = head_word[11:4];
    else
      queue_byte = {head_word[3:0], 3'b000, 1'b1};
  end

  // read multiplexer; unmapped indices read zero
  always_comb begin
    if (hit(idx, `IDX_QUEUE_STATUS))
      rbyte = {overrun, 1'b0, count};
    else if (hit(idx, `IDX_NV_CONTROL))
      rbyte = {NVM_REMAIN, 1'b0, ~NVM_BUSY, 1'b0, prog_mode};
    else if (hit(idx, `IDX_COMP_CONTROL))
      rbyte = {3'b000, cal_rdy, 4'h0};
    else if (hit(idx, `IDX_OFFSET_X))
      rbyte = off_x;
    else if (hit(idx, `IDX_OFFSET_Y))
      rbyte = off_y;
    else if (hit(idx, `IDX_OFFSET_Z))
      rbyte = off_z;
    else if (hit(idx, `IDX_NV_IMAGE_A))
      rbyte = spare_byte_a;
    else if (hit(idx, `IDX_NV_IMAGE_B))
      rbyte = spare_byte_b;
    else if (hit(idx, `IDX_QUEUE_CONFIG))
      rbyte = {q_mode, 4'h0, q_sel};
    else if (hit(idx, `IDX_QUEUE_READOUT))
      rbyte = queue_byte;
    else
      rbyte = 8'h00;
  end

  // read data, burst pointer and full flag
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA     <= 32'h0;
      NEXT_BURST_INDEX <= 6'h00;
      FIFO_FULL        <= 1'b0;
    end else begin
      if (rd_acc) begin
        AVS_READDATA     <= {24'h0, rbyte};
        NEXT_BURST_INDEX <= burst_next(idx);
      end
      FIFO_FULL <= q_full && !(init || cfg_write);
    end
  end

endmodule // accel_offset_fifo_regs

// File: bench/accel_offset_fifo_regs_chk.sv
// assertions on the ports of the offset and queue register group
// assumes one clock; bound to every instance at the foot of this file
`timescale 1ns/1ps
module accel_offset_fifo_regs_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESETN,
  // register bus
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  // side ports
  input wire logic [5:0]  NEXT_BURST_INDEX,
  input wire logic        SAMPLE_VALID,
  input wire logic        FIFO_FULL,
  input wire logic        CAL_START,
  input wire logic [1:0]  CAL_AXIS,
  input wire logic        NVM_PROG,
  input wire logic [3:0]  NVM_REMAIN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // a write the slave takes at this edge
  logic take_w;
  assign take_w = AVS_WRITE && AVS_WAITREQUEST && AVS_BYTEENABLE[0];

  property p_one_wait;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not one cycle after request");
  property p_low_once;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  a_low_once: assert property (p_low_once)
    else $error("waitrequest low longer than one cycle");
  property p_no_spur;
    $fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE);
  endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("answer without request");
  property p_cal_pulse;
    CAL_START |-> (CAL_AXIS != 2'b00) ##1 !CAL_START;
  endproperty
  a_cal_pulse: assert property (p_cal_pulse)
    else $error("compensation start not a one-cycle axis pulse");
  property p_cal_cause;
    CAL_START |-> $past(take_w) && $past(AVS_ADDRESS[7:2]) == 6'h36
      && $past(AVS_WRITEDATA[6:5]) == CAL_AXIS;
  endproperty
  a_cal_cause: assert property (p_cal_cause)
    else $error("compensation start without matching trigger");
  property p_prog_cause;
    NVM_PROG |-> $past(take_w) && $past(AVS_ADDRESS[7:2]) == 6'h33
      && $past(AVS_WRITEDATA[1]) && $past(NVM_REMAIN) != 4'h0;
  endproperty
  a_prog_cause: assert property (p_prog_cause)
    else $error("store programmed without accepted request");
  property p_full_cause;
    $rose(FIFO_FULL) |-> $past(SAMPLE_VALID, 2);
  endproperty
  a_full_cause: assert property (p_full_cause)
    else $error("queue full without a sample");
  property p_cfg_clear;
    take_w && AVS_ADDRESS[7:2] == 6'h3e |=> !FIFO_FULL;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear)
    else $error("queue full survives config write");
  property p_burst_hold;
    AVS_READ && AVS_WAITREQUEST && AVS_ADDRESS[7:2] == 6'h3f
      |=> NEXT_BURST_INDEX == 6'h3f;
  endproperty
  a_burst_hold: assert property (p_burst_hold)
    else $error("burst index moved off readout");
endmodule // accel_offset_fifo_regs_chk

bind accel_offset_fifo_regs accel_offset_fifo_regs_chk u_chk (
  .CLK(CLK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .NEXT_BURST_INDEX(NEXT_BURST_INDEX),
  .SAMPLE_VALID(SAMPLE_VALID), .FIFO_FULL(FIFO_FULL),
  .CAL_START(CAL_START), .CAL_AXIS(CAL_AXIS), .NVM_PROG(NVM_PROG),
  .NVM_REMAIN(NVM_REMAIN));

// File: bench/nvm_cal_model.sv
// model of the store and compensation engine beside the register group
// assumes one clock; result line is garbage outside its done pulse
`timescale 1ns/1ps
module nvm_cal_model #(
  parameter logic [39:0] IMAGE  = 40'h2a190cf310,
  parameter logic [7:0]  RESULT = 8'h5d,
  parameter int          LAT    = 6
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // compensation engine
  input  wire logic        cal_start,
  output logic             cal_done,
  output logic [7:0]       cal_result,
  // store
  input  wire logic        nvm_prog,
  output logic             nvm_busy,
  output logic [3:0]       nvm_remain,
  output logic [39:0]      nvm_image,
  output int               prog_cnt
);
  int cal_cnt;
  int busy_cnt;

  // store contents and write budget
  assign nvm_image  = IMAGE;
  assign nvm_remain = 4'h5 - prog_cnt[3:0];
  assign nvm_busy   = busy_cnt != 0;
  assign cal_result = cal_done ? RESULT : ~RESULT;

  // slow engine answer; store busy a few cycles after each write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_cnt  <= 0;
      cal_done <= 1'b0;
      busy_cnt <= 0;
      prog_cnt <= 0;
    end else begin
      cal_done <= cal_cnt == 1;
      if (cal_start) cal_cnt <= LAT;
      else if (cal_cnt != 0) cal_cnt <= cal_cnt - 1;
      if (nvm_prog) begin
        prog_cnt <= prog_cnt + 1;
        busy_cnt <= 4;
      end else if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    end
  end
endmodule // nvm_cal_model

// File: bench/accel_offset_fifo_regs_tb.sv
// self-checking bench for the offset and queue register group
// assumes the store/compensation model and the bound checker
`timescale 1ns/1ps
module accel_offset_fifo_regs_tb;
  localparam logic [39:0] IMG = 40'h2a190cf310;
  localparam logic [7:0]  RES = 8'h5d;
  logic        clk = 0, rst_n = 0, rd_en = 0, wr_en = 0, bend = 0, sv = 0;
  logic [7:0]  adr = 0, q;
  logic [31:0] wdat = 0, rdat;
  logic [1:0]  rng = 0, cal_ax;
  logic [11:0] fx = 0, fy = 0, fz = 0, cfx, crx, cfy, cfz, cry, crz;
  logic        wait_rq, full, cal_go, cal_done, busy, prog;
  logic [5:0]  nbi;
  logic [7:0]  cal_res;
  logic [3:0]  remain;
  logic [39:0] image, pdat;
  int          error_cnt = 0, checked = 0, prog_cnt;

  accel_offset_fifo_regs dut (
    .CLK(clk), .RESETN(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
    .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_rq),
    .HOST_BURST_END(bend), .NEXT_BURST_INDEX(nbi), .SAMPLE_VALID(sv),
    .G_RANGE(rng), .DATA_FILT_X(fx), .DATA_FILT_Y(fy), .DATA_FILT_Z(fz),
    .DATA_RAW_X(fx), .DATA_RAW_Y(fy), .DATA_RAW_Z(fz),
    .COMP_FILT_X(cfx), .COMP_FILT_Y(cfy), .COMP_FILT_Z(cfz),
    .COMP_RAW_X(crx), .COMP_RAW_Y(cry), .COMP_RAW_Z(crz),
    .FIFO_FULL(full), .CAL_START(cal_go),
    .CAL_AXIS(cal_ax), .CAL_DONE(cal_done), .CAL_RESULT(cal_res),
    .NVM_BUSY(busy), .NVM_REMAIN(remain), .NVM_IMAGE(image),
    .NVM_PROG(prog), .NVM_PROG_DATA(pdat));

  nvm_cal_model #(.IMAGE(IMG), .RESULT(RES)) u_far (
    .clk(clk), .rst_n(rst_n), .cal_start(cal_go), .cal_done(cal_done),
    .cal_result(cal_res), .nvm_prog(prog), .nvm_busy(busy),
    .nvm_remain(remain), .nvm_image(image), .prog_cnt(prog_cnt));

  // free-running clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    q = rdat[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // compensated x output for one offset, range and sample
  task automatic comp(input logic [7:0] o, input logic [1:0] r,
                      input logic [11:0] d, e);
    wr(8'he0, o);
    rng <= r;
    fx <= d;
    repeat (3) @(posedge clk);
    chk(cfx, e);
    chk(crx, e);
  endtask
  task automatic restored;
    for (int i = 0; i < 5; i++) rd(8'he0 + 8'(4 * i), IMG[8 * i +: 8]);
  endtask
  // sample k carries 0x100+k, 0x200+k, 0x300+k on x, y, z
  task automatic fill(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      fx <= 12'h100 + 12'(k);
      fy <= 12'h200 + 12'(k);
      fz <= 12'h300 + 12'(k);
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
    end
  endtask
  task automatic frame(input int k, input int sel);
    logic [11:0] d;
    for (int a = 0; a < 3; a++) begin
      if (sel == 0 || sel == a + 1) begin
        d = 12'(12'h100 * (a + 1) + k);
        rd(8'hfc, {d[3:0], 4'h1});
        rd(8'hfc, d[11:4]);
      end
    end
  endtask

  task automatic stop_test;
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, well past the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    stop_test;
  end

  // mode code 11 is never programmed below
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    restored;
    rd(8'hf8, 8'h00);
    rd(8'hf4, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(8'he0 + 8'(4 * i), 8'h31 + 8'(i));
      rd(8'he0 + 8'(4 * i), 8'h31 + 8'(i));
    end
    $display("test registers done");
    for (int r = 0; r < 4; r++)
      comp(8'h10, 2'(r), 12'h100, 12'h100 + (12'h080 >> r));
    comp(8'h7f, 2'b00, 12'h7f0, 12'h7ff);
    comp(8'h80, 2'b00, 12'h800, 12'h800);
    $display("test offset math done");
    for (int ax = 1; ax < 4; ax++) begin
      wr(8'hd8, {1'b0, 2'(ax), 5'h00});
      q = 8'h00;
      for (int n = 0; n < 30 && q[4] !== 1'b1; n++) bus(1'b0, 8'hd8, 8'h00);
      rd(8'hdc + 8'(4 * ax), RES);
    end
    $display("test compensation done");
    wr(8'hcc, 8'h02);
    repeat (3) @(posedge clk);
    chk(prog_cnt, 0);
    wr(8'hcc, 8'h01);
    wr(8'hcc, 8'h03);
    repeat (3) @(posedge clk);
    chk(prog_cnt, 1);
    chk(pdat[31:0], 32'h345d5d5d);
    chk(pdat[39:32], 8'h35);
    $display("test store done");
    wr(8'h50, 8'hb6);
    restored;
    chk({cfy, cfz}, {12'hf98, 12'h060});
    chk({cry, crz}, {12'hf98, 12'h060});
    wr(8'hd8, 8'h80);
    for (int i = 0; i < 3; i++) rd(8'he0 + 8'(4 * i), 8'h00);
    wr(8'hcc, 8'h08);
    restored;
    wr(8'hd8, 8'h80);
    $display("test resets done");
    wr(8'hf8, 8'h40);
    fill(2);
    frame(0, 0);
    frame(1, 0);
    rd(8'hfc, 8'h00);
    chk(nbi, 6'h3f);
    rd(8'he0, 8'h00);
    chk(nbi, 6'h39);
    for (int s = 1; s < 4; s++) begin
      wr(8'hf8, 8'h40 + 8'(s));
      fill(2);
      frame(0, s);
      frame(1, s);
    end
    wr(8'hf8, 8'h40);
    fill(2);
    rd(8'hfc, 8'h01);
    @(posedge clk);
    bend <= 1'b1;
    @(posedge clk);
    bend <= 1'b0;
    frame(1, 0);
    $display("test readout done");
    wr(8'hf8, 8'h40);
    fill(33);
    repeat (2) @(posedge clk);
    chk(full, 1'b1);
    for (int k = 0; k < 32; k++) frame(k, 0);
    rd(8'hfc, 8'h00);
    wr(8'hf8, 8'h80);
    fill(34);
    wr(8'hf8, 8'h80);
    chk(full, 1'b0);
    rd(8'hfc, 8'h00);
    fill(34);
    for (int k = 2; k < 34; k++) frame(k, 0);
    wr(8'hf8, 8'h00);
    fill(3);
    frame(2, 0);
    rd(8'hfc, 8'h00);
    $display("test queue modes done");
    stop_test;
  end
endmodule // accel_offset_fifo_regs_tb
